// *** pci_pkg.sv ***
// Shared constants and types of the calibration, averaging and interrupt register bank.
`default_nettype none

package pci_pkg;

    // Register offsets.
    localparam logic [7:0] PCI_OFS_CALIB_CONFIG = 8'hD9;
    localparam logic [7:0] PCI_OFS_CALIB_STATUS = 8'hDC;
    localparam logic [7:0] PCI_OFS_INT_ENABLE   = 8'hDD;

    // Field positions of calibration_config.
    localparam int PCI_CFG_TARGET_LSB = 5;
    localparam int PCI_CFG_TARGET_MSB = 7;
    localparam int PCI_CFG_RSVD_BIT   = 4;
    localparam int PCI_CFG_AVG_LSB    = 0;
    localparam int PCI_CFG_AVG_MSB    = 2;

    // Field positions of calibration_status and interrupt_enable.
    localparam int PCI_STAT_DONE_BIT = 0;
    localparam int PCI_IEN_ASAT_BIT  = 7;
    localparam int PCI_IEN_PSAT_BIT  = 6;
    localparam int PCI_IEN_PROX_BIT  = 5;
    localparam int PCI_IEN_ALS_BIT   = 4;
    localparam int PCI_IEN_CAL_BIT   = 3;

    // Reset values.
    localparam logic [2:0] PCI_RST_TARGET = 3'h2;
    localparam logic       PCI_RST_RSVD   = 1'h1;
    localparam logic [2:0] PCI_RST_AVG    = 3'h0;
    localparam logic       PCI_RST_DONE   = 1'h0;
    localparam logic [4:0] PCI_RST_IEN    = 5'h00;

    // Data path widths.
    localparam int PCI_ADC_W = 10;
    localparam int PCI_OFS_W = 8;
    localparam int PCI_ACC_W = 17;

    // Offset search states, Gray coded along the search loop.
    typedef enum logic [1:0]
    {
        PCI_CAL_IDLE   = 2'h0,
        PCI_CAL_TRIAL  = 2'h1,
        PCI_CAL_WAIT   = 2'h3,
        PCI_CAL_FINISH = 2'h2
    } pci_cal_state_t;

    // Mask of ADC bits that count during search and zero detection.
    function automatic logic [PCI_ADC_W-1:0] pci_target_mask(input logic [2:0] code);
        logic [PCI_ADC_W-1:0] target;
        target = 10'((10'h001 << code) - 10'h001);
        return ~{target[7:0], 2'h3};
    endfunction

endpackage

`default_nettype wire

// *** pci_offset_search.sv ***
// Binary search of the proximity offset against the masked ADC target.
`default_nettype none

module pci_offset_search
(
    // Clock and reset
    input  wire logic                           sys_clk,
    input  wire logic                           resetn,
    // Control
    input  wire logic                           start,
    input  wire logic                           stop,
    input  wire logic [2:0]                     target_code,
    // ADC handshake
    output logic                                adc_req,
    input  wire logic                           adc_valid,
    input  wire logic [pci_pkg::PCI_ADC_W-1:0]  adc_data,
    // Results
    output logic [pci_pkg::PCI_OFS_W-1:0]       trial_offset,
    output logic [pci_pkg::PCI_OFS_W-1:0]       offset_result,
    output logic                                busy,
    output logic                                done
);
    import pci_pkg::*;

    pci_cal_state_t            state_q, state_d;
    logic [PCI_OFS_W-1:0]      trial_q, trial_d;
    logic [PCI_OFS_W-1:0]      bit_q, bit_d;
    logic [PCI_OFS_W-1:0]      result_q, result_d;
    logic [PCI_ADC_W-1:0]      mask_q, mask_d;
    logic                      req_q, req_d;
    logic                      done_q, done_d;
    logic                      busy_q, busy_d;

    always_comb
    begin
        state_d  = state_q;
        trial_d  = trial_q;
        bit_d    = bit_q;
        result_d = result_q;
        mask_d   = mask_q;
        req_d    = 1'b0;
        done_d   = 1'b0;
        case (state_q)
            PCI_CAL_IDLE:
            begin
                if (start)
                begin
                    // The mask is frozen for the whole search.
                    mask_d  = pci_target_mask(target_code);
                    bit_d   = 8'h80;
                    trial_d = 8'h80;
                    state_d = PCI_CAL_TRIAL;
                end
            end
            PCI_CAL_TRIAL:
            begin
                req_d   = 1'b1;
                state_d = PCI_CAL_WAIT;
            end
            PCI_CAL_WAIT:
            begin
                if (adc_valid)
                begin
                    // A positive masked value means the offset is still too small.
                    if ((adc_data & mask_q) == 10'h000)
                    begin
                        trial_d = trial_q & ~bit_q;
                    end
                    if (bit_q == 8'h01)
                    begin
                        state_d = PCI_CAL_FINISH;
                    end
                    else
                    begin
                        bit_d   = bit_q >> 1;
                        state_d = PCI_CAL_TRIAL;
                    end
                end
            end
            PCI_CAL_FINISH:
            begin
                result_d = trial_q;
                done_d   = 1'b1;
                state_d  = PCI_CAL_IDLE;
            end
            default:
            begin
                state_d = PCI_CAL_IDLE;
            end
        endcase
        if (state_q == PCI_CAL_TRIAL && trial_d == trial_q && bit_q != 8'h80)
        begin
            trial_d = trial_q;
        end
        if (state_q == PCI_CAL_WAIT && adc_valid && bit_q != 8'h01)
        begin
            trial_d = trial_d | (bit_q >> 1);
        end
        if (stop && state_q != PCI_CAL_IDLE)
        begin
            // Abort keeps the previous result and reports nothing.
            state_d  = PCI_CAL_IDLE;
            result_d = result_q;
            done_d   = 1'b0;
            req_d    = 1'b0;
        end
        // Busy is registered so the top-level status comes straight from a flip-flop.
        busy_d = (state_d != PCI_CAL_IDLE);
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q  <= PCI_CAL_IDLE;
            trial_q  <= 8'h00;
            bit_q    <= 8'h00;
            result_q <= 8'h00;
            mask_q   <= 10'h000;
            req_q    <= 1'b0;
            done_q   <= 1'b0;
            busy_q   <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            trial_q  <= trial_d;
            bit_q    <= bit_d;
            result_q <= result_d;
            mask_q   <= mask_d;
            req_q    <= req_d;
            done_q   <= done_d;
            busy_q   <= busy_d;
        end
    end

    assign adc_req       = req_q;
    assign trial_offset  = trial_q;
    assign offset_result = result_q;
    assign busy          = busy_q;
    assign done          = done_q;

endmodule

`default_nettype wire

// *** pci_prox_average.sv ***
// Windowed averaging of proximity samples into the proximity result.
`default_nettype none

module pci_prox_average
(
    // Clock and reset
    input  wire logic                           sys_clk,
    input  wire logic                           resetn,
    // Configuration
    input  wire logic [2:0]                     avg_code,
    // Samples
    input  wire logic                           sample_valid,
    input  wire logic [pci_pkg::PCI_ADC_W-1:0]  sample_data,
    // Result
    output logic [pci_pkg::PCI_ADC_W-1:0]       result,
    output logic                                result_valid
);
    import pci_pkg::*;

    logic [PCI_ACC_W-1:0] acc_q, acc_d;
    logic [6:0]           cnt_q, cnt_d;
    logic [2:0]           code_q, code_d;
    logic [PCI_ADC_W-1:0] res_q, res_d;
    logic                 vld_q, vld_d;
    logic [PCI_ACC_W-1:0] sum;
    logic [6:0]           last;

    always_comb
    begin
        sum    = acc_q + PCI_ACC_W'(sample_data);
        last   = 7'((8'h01 << avg_code) - 8'h01);
        acc_d  = acc_q;
        cnt_d  = cnt_q;
        code_d = avg_code;
        res_d  = res_q;
        vld_d  = 1'b0;
        if (avg_code != code_q)
        begin
            // A new window size starts a fresh window, a mixed one would be meaningless.
            acc_d = '0;
            cnt_d = 7'h00;
        end
        else if (sample_valid)
        begin
            if (cnt_q == last)
            begin
                res_d = PCI_ADC_W'(sum >> avg_code);
                vld_d = 1'b1;
                acc_d = '0;
                cnt_d = 7'h00;
            end
            else
            begin
                acc_d = sum;
                cnt_d = 7'(cnt_q + 7'h01);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            acc_q  <= '0;
            cnt_q  <= 7'h00;
            code_q <= PCI_RST_AVG;
            res_q  <= 10'h000;
            vld_q  <= 1'b0;
        end
        else
        begin
            acc_q  <= acc_d;
            cnt_q  <= cnt_d;
            code_q <= code_d;
            res_q  <= res_d;
            vld_q  <= vld_d;
        end
    end

    assign result       = res_q;
    assign result_valid = vld_q;

endmodule

`default_nettype wire

// *** pci_regs.sv ***
// Calibration, averaging and interrupt enable registers with their engines.
//
// Function
// - Target code n selects ADC target two to the n minus one.
// - Target is scaled by four; lowest two ADC bits always ignored.
// - ADC values are ANDed with the target mask before the zero test.
// - Proximity result updates only at the end of each fixed window.
// - Averaging code 0 disables; codes 1 to 7 give 2 to 128 samples.
// - Calibration done bit sets on finish, clears on host write of one.
// - Calibration done raises interrupt only while its enable is set.
// - Enable bit 7 enables ambient saturation interrupt, resets to zero.
// - Enable bit 6 enables proximity saturation interrupt, resets to zero.
// - Enable bit 5 enables proximity threshold interrupt, resets to zero.
// - Enable bit 4 enables ambient threshold interrupt, resets to zero.
// - Enable bit 3 enables calibration done interrupt, resets to zero.
// - Calibration start stores search result in offset, then flags done.
`default_nettype none

module pci_regs
(
    // Clock and reset
    input  wire logic                           sys_clk,
    input  wire logic                           resetn,
    // Register port
    input  wire logic [7:0]                     reg_addr,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    input  wire logic [7:0]                     reg_wdata,
    output logic [7:0]                          reg_rdata,
    // Calibration control
    input  wire logic                           calib_start,
    input  wire logic                           calib_stop,
    output logic                                calib_busy,
    // Offset search ADC handshake
    output logic                                adc_req,
    input  wire logic                           adc_valid,
    input  wire logic [pci_pkg::PCI_ADC_W-1:0]  adc_data,
    output logic [pci_pkg::PCI_OFS_W-1:0]       trial_offset,
    output logic [pci_pkg::PCI_OFS_W-1:0]       proximity_offset,
    // Proximity samples and result
    input  wire logic                           prox_valid,
    input  wire logic [pci_pkg::PCI_ADC_W-1:0]  prox_data,
    output logic [pci_pkg::PCI_ADC_W-1:0]       proximity_result,
    output logic                                proximity_result_valid,
    // Other interrupt sources
    input  wire logic                           asat_flag,
    input  wire logic                           psat_flag,
    input  wire logic                           prox_flag,
    input  wire logic                           als_flag,
    // Interrupt
    output logic                                irq
);
    import pci_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Register state.

    logic [2:0] target_q, target_d;
    logic       rsvd_q, rsvd_d;
    logic [2:0] avg_q, avg_d;
    logic       done_flag_q, done_flag_d;
    logic [4:0] ien_q, ien_d;
    logic [7:0] rdata_q, rdata_d;
    logic       irq_q, irq_d;

    logic       wr_cfg;
    logic       wr_stat;
    logic       wr_ien;
    logic       cal_done;
    logic       cal_busy;
    logic [7:0] rd_mux;

    assign wr_cfg  = reg_wr && (reg_addr == PCI_OFS_CALIB_CONFIG);
    assign wr_stat = reg_wr && (reg_addr == PCI_OFS_CALIB_STATUS);
    assign wr_ien  = reg_wr && (reg_addr == PCI_OFS_INT_ENABLE);

    ////////////////////////////////////////////////////////////////////////////////
    // Engines.

    pci_offset_search u_search
    (
        .sys_clk       (sys_clk),
        .resetn        (resetn),
        .start         (calib_start),
        .stop          (calib_stop),
        .target_code   (target_q),
        .adc_req       (adc_req),
        .adc_valid     (adc_valid),
        .adc_data      (adc_data),
        .trial_offset  (trial_offset),
        .offset_result (proximity_offset),
        .busy          (cal_busy),
        .done          (cal_done)
    );

    pci_prox_average u_average
    (
        .sys_clk      (sys_clk),
        .resetn       (resetn),
        .avg_code     (avg_q),
        .sample_valid (prox_valid),
        .sample_data  (prox_data),
        .result       (proximity_result),
        .result_valid (proximity_result_valid)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes, status flag and interrupt.

    always_comb
    begin
        target_d    = target_q;
        rsvd_d      = rsvd_q;
        avg_d       = avg_q;
        ien_d       = ien_q;
        done_flag_d = done_flag_q;
        if (wr_cfg)
        begin
            target_d = reg_wdata[PCI_CFG_TARGET_MSB:PCI_CFG_TARGET_LSB];
            rsvd_d   = reg_wdata[PCI_CFG_RSVD_BIT];
            avg_d    = reg_wdata[PCI_CFG_AVG_MSB:PCI_CFG_AVG_LSB];
        end
        if (wr_ien)
        begin
            ien_d = reg_wdata[PCI_IEN_ASAT_BIT:PCI_IEN_CAL_BIT];
        end
        if (wr_stat && reg_wdata[PCI_STAT_DONE_BIT])
        begin
            done_flag_d = 1'b0;
        end
        // A finish in the same cycle as the clear must not be lost.
        if (cal_done)
        begin
            done_flag_d = 1'b1;
        end
        // The output follows the flags a cycle later, so it stays up only while an enabled flag is set.
        irq_d = (done_flag_q && ien_q[PCI_IEN_CAL_BIT-3])
              | (als_flag    && ien_q[PCI_IEN_ALS_BIT-3])
              | (prox_flag   && ien_q[PCI_IEN_PROX_BIT-3])
              | (psat_flag   && ien_q[PCI_IEN_PSAT_BIT-3])
              | (asat_flag   && ien_q[PCI_IEN_ASAT_BIT-3]);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data, registered one cycle after the read strobe.

    always_comb
    begin
        case (reg_addr)
            PCI_OFS_CALIB_CONFIG: rd_mux = {target_q, rsvd_q, 1'b0, avg_q};
            PCI_OFS_CALIB_STATUS: rd_mux = {7'h00, done_flag_q};
            PCI_OFS_INT_ENABLE:   rd_mux = {ien_q, 3'h0};
            default:              rd_mux = 8'h00;
        endcase
        rdata_d = reg_rd ? rd_mux : rdata_q;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            target_q    <= PCI_RST_TARGET;
            rsvd_q      <= PCI_RST_RSVD;
            avg_q       <= PCI_RST_AVG;
            ien_q       <= PCI_RST_IEN;
            done_flag_q <= PCI_RST_DONE;
            rdata_q     <= 8'h00;
            irq_q       <= 1'b0;
        end
        else
        begin
            target_q    <= target_d;
            rsvd_q      <= rsvd_d;
            avg_q       <= avg_d;
            ien_q       <= ien_d;
            done_flag_q <= done_flag_d;
            rdata_q     <= rdata_d;
            irq_q       <= irq_d;
        end
    end

    assign reg_rdata  = rdata_q;
    assign irq        = irq_q;
    assign calib_busy = cal_busy;

endmodule

`default_nettype wire

// *** pci_regs_sva.sv ***
// Concurrent checks of the register bank at its top-level ports.
`default_nettype none

module pci_regs_sva
(
    // Clock and reset
    input wire logic                          sys_clk,
    input wire logic                          resetn,
    // Register port
    input wire logic [7:0]                    reg_addr,
    input wire logic                          reg_wr,
    input wire logic                          reg_rd,
    input wire logic [7:0]                    reg_wdata,
    input wire logic [7:0]                    reg_rdata,
    // Calibration
    input wire logic                          calib_start,
    input wire logic                          calib_stop,
    input wire logic                          calib_busy,
    input wire logic                          adc_req,
    input wire logic [pci_pkg::PCI_OFS_W-1:0] trial_offset,
    input wire logic [pci_pkg::PCI_OFS_W-1:0] proximity_offset,
    // Averaging
    input wire logic                          prox_valid,
    input wire logic [pci_pkg::PCI_ADC_W-1:0] prox_data,
    input wire logic [pci_pkg::PCI_ADC_W-1:0] proximity_result,
    input wire logic                          proximity_result_valid,
    // Interrupt
    input wire logic                          asat_flag,
    input wire logic                          psat_flag,
    input wire logic                          prox_flag,
    input wire logic                          als_flag,
    input wire logic                          irq
);
    import pci_pkg::*;

    // Shadows of the enable bits and averaging code, rebuilt from the writes seen at the port.
    logic [4:0] en_q;
    logic [4:0] en_d;
    logic [2:0] avg_q;
    logic [2:0] avg_d;
    logic       cfg_wr;
    logic [3:0] src;
    logic       mapped;

    assign cfg_wr = reg_wr && reg_addr == PCI_OFS_CALIB_CONFIG;
    assign src    = {asat_flag, psat_flag, prox_flag, als_flag} & en_q[4:1];
    assign mapped = reg_addr == PCI_OFS_CALIB_CONFIG || reg_addr == PCI_OFS_CALIB_STATUS
                    || reg_addr == PCI_OFS_INT_ENABLE;

    always_comb
    begin
        en_d  = en_q;
        avg_d = avg_q;
        if (reg_wr && reg_addr == PCI_OFS_INT_ENABLE)
            en_d = reg_wdata[7:3];
        if (cfg_wr)
            avg_d = reg_wdata[2:0];
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            en_q  <= 5'h00;
            avg_q <= 3'h0;
        end
        else
        begin
            en_q  <= en_d;
            avg_q <= avg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_start;
        calib_start && !calib_busy && !calib_stop;
    endsequence

    sequence s_first_trial;
        calib_busy && trial_offset == 8'h80 ##1 adc_req;
    endsequence

    a_first_trial: assert property (s_start |=> s_first_trial)
        else $error("first trial missing after start");
    a_req_pulse: assert property (adc_req |=> !adc_req)
        else $error("conversion request longer than one cycle");
    a_offset_change: assert property ($changed(proximity_offset) |-> $past(calib_busy))
        else $error("offset changed outside a search");
    a_result_update: assert property ($changed(proximity_result) |-> proximity_result_valid)
        else $error("result changed outside a window end");
    a_avg_off: assert property (avg_q == 3'h0 && prox_valid && !cfg_wr && !$past(cfg_wr)
        |=> proximity_result_valid && proximity_result == $past(prox_data))
        else $error("sample not passed through with averaging off");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_irq_enabled: assert property (src != 4'h0 |=> irq)
        else $error("enabled flag did not raise irq");
    a_irq_masked: assert property (!en_q[0] && src == 4'h0 |=> !irq)
        else $error("irq without an enabled source");

endmodule

bind pci_regs pci_regs_sva u_sva
(
    .sys_clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .calib_start, .calib_stop, .calib_busy, .adc_req, .trial_offset, .proximity_offset,
    .prox_valid, .prox_data, .proximity_result, .proximity_result_valid,
    .asat_flag, .psat_flag, .prox_flag, .als_flag, .irq
);

`default_nettype wire

// *** pci_adc_model.sv ***
// Behavioural ADC that answers each conversion request of the offset search.
`default_nettype none

module pci_adc_model
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // Conversion handshake
    input  wire logic       adc_req,
    input  wire logic [7:0] trial_offset,
    output logic            adc_valid,
    output logic [9:0]      adc_data,
    // Scene chosen by the bench
    input  wire logic [7:0] thr,
    input  wire logic [9:0] hi,
    input  wire logic [9:0] lo,
    input  wire logic       slow
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        adc_valid = 1'b0;
        adc_data  = 10'h000;
    end

    // Offsets up to the threshold see the bright level. Data is inverted
    // once released so a stale value can never be mistaken for a conversion.
    always @(posedge sys_clk)
    begin
        if (resetn && adc_req)
        begin
            repeat (slow ? 6 : 1) @(posedge sys_clk);
            #1;
            adc_valid = 1'b1;
            adc_data  = (trial_offset <= thr) ? hi : lo;
            @(posedge sys_clk);
            #1;
            adc_valid = 1'b0;
            adc_data  = ~adc_data;
        end
    end

endmodule

`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench of the register bank driven through its register strobes.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pci_pkg::*;

    logic       sys_clk = 1'b0;
    logic       resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic       calib_start = 1'b0;
    logic       calib_busy;
    logic       adc_req;
    logic       adc_valid;
    logic [9:0] adc_data;
    logic [7:0] trial_offset;
    logic [7:0] proximity_offset;
    logic       prox_valid = 1'b0;
    logic [9:0] prox_data = 10'h000;
    logic [9:0] proximity_result;
    logic       proximity_result_valid;
    logic [3:0] fl = 4'h0;
    logic       irq;
    logic [7:0] thr = 8'h00;
    logic [9:0] hi = 10'h000;
    logic [9:0] lo = 10'h000;
    logic       slow = 1'b0;
    int         n_fail = 0;
    int         n_tests = 0;
    int         b;

    always #12.5 sys_clk = ~sys_clk;

    pci_regs u_dut
    (
        .sys_clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .calib_start, .calib_stop(1'b0), .calib_busy, .adc_req, .adc_valid, .adc_data,
        .trial_offset, .proximity_offset, .prox_valid, .prox_data, .proximity_result,
        .proximity_result_valid, .asat_flag(fl[3]), .psat_flag(fl[2]), .prox_flag(fl[1]),
        .als_flag(fl[0]), .irq
    );

    pci_adc_model u_adc
    (
        .sys_clk, .resetn, .adc_req, .trial_offset, .adc_valid, .adc_data,
        .thr, .hi, .lo, .slow
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        // One idle edge keeps strobes of back-to-back calls apart and lets a new
        // averaging code settle before samples arrive.
        tick(1);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd   = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        check(what, reg_rdata, exp);
        tick(1);
    endtask

    // The search runs to completion under a bounded wait.
    task automatic run_calib;
        int i;
        calib_start = 1'b1;
        tick(1);
        calib_start = 1'b0;
        for (i = 0; i < 500 && calib_busy !== 1'b0; i++)
            tick(1);
        if (i == 500)
        begin
            n_fail++;
            finish_test();
        end
        tick(2);
    endtask

    // Back-to-back samples fill one window; exactly one update must follow.
    task automatic avg_run(input int k);
        int i;
        int sum;
        int nv;
        sum = 0;
        nv  = 0;
        wr(PCI_OFS_CALIB_CONFIG, 8'h50 | 8'(k));
        prox_valid = 1'b1;
        for (i = 0; i < (1 << k); i++)
        begin
            prox_data = 10'((i * 37 + k * 5) % 1024);
            sum += int'(prox_data);
            tick(1);
            nv += int'(proximity_result_valid === 1'b1);
        end
        prox_valid = 1'b0;
        tick(1);
        nv += int'(proximity_result_valid === 1'b1);
        check("window updates", 16'(nv), 16'h0001);
        check("average", proximity_result, 10'(sum >> k));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        tick(1);
        rd_chk("config", PCI_OFS_CALIB_CONFIG, 8'h50);
        rd_chk("status", PCI_OFS_CALIB_STATUS, 8'h00);
        rd_chk("enable", PCI_OFS_INT_ENABLE, 8'h00);
        wr(PCI_OFS_INT_ENABLE, 8'hFF);
        rd_chk("enable", PCI_OFS_INT_ENABLE, 8'hF8);
        wr(8'hDA, 8'hFF);
        rd_chk("unmapped", 8'hDA, 8'h00);
        check("irq idle", irq, 1'b0);
        $display("test registers done");
        for (b = 0; b < 4; b++)
        begin
            fl = 4'(1 << b);
            wr(PCI_OFS_INT_ENABLE, 8'hF8 ^ 8'(8'h10 << b));
            tick(1);
            check("irq masked", irq, 1'b0);
            wr(PCI_OFS_INT_ENABLE, 8'(8'h10 << b));
            tick(1);
            check("irq enabled", irq, 1'b1);
            fl = 4'h0;
            tick(2);
            check("irq cleared", irq, 1'b0);
        end
        wr(PCI_OFS_INT_ENABLE, 8'h00);
        $display("test interrupt sources done");
        thr = 8'h5A;
        for (b = 0; b < 8; b++)
        begin
            // Bright level sits on the mask boundary, dark level one below it.
            hi   = 10'((1 << b) * 4);
            lo   = hi - 10'h001;
            slow = b[0];
            wr(PCI_OFS_CALIB_CONFIG, {3'(b), 5'h10});
            run_calib();
            check("offset", proximity_offset, 8'h5A);
            rd_chk("done", PCI_OFS_CALIB_STATUS, 8'h01);
            check("irq no enable", irq, 1'b0);
            wr(PCI_OFS_CALIB_STATUS, 8'h00);
            rd_chk("done kept", PCI_OFS_CALIB_STATUS, 8'h01);
            wr(PCI_OFS_INT_ENABLE, 8'h08);
            tick(1);
            check("irq done", irq, 1'b1);
            wr(PCI_OFS_CALIB_STATUS, 8'h01);
            tick(1);
            check("irq after clear", irq, 1'b0);
            rd_chk("done cleared", PCI_OFS_CALIB_STATUS, 8'h00);
            wr(PCI_OFS_INT_ENABLE, 8'h00);
        end
        $display("test calibration done");
        for (b = 0; b < 8; b++)
            avg_run(b);
        $display("test averaging done");
        finish_test();
    end

endmodule

`default_nettype wire
